// >>> core/lsr_pkg.sv
// Purpose: Constants for the logical right shift execution block
// Assumes: 16-bit words, 24-bit instruction words
// Notes: Opcode patterns and field positions for the three shift forms
package lsr_pkg;
   localparam int WORD_W = 16;
   localparam int INSN_W = 24;
   // Opcode pattern of the single-position form, bits 23:15
   localparam logic [8:0] OPC_ONE = 9'h1a2;
   // Opcode pattern of the two amount forms, bits 23:15
   localparam logic [8:0] OPC_AMT = 9'h1bc;
   // Bits 6:4 of the amount forms choose the amount source
   localparam logic [2:0] AMT_LIT = 3'h4;
   localparam logic [2:0] AMT_REG = 3'h0;
   // Field positions
   localparam int OPC_HI = 23;
   localparam int OPC_LO = 15;
   localparam int BYTE_BIT = 14;
   localparam int DMODE_LO = 11;
   localparam int DREG_LO = 7;
   localparam int SMODE_LO = 4;
   localparam int SREG_LO = 0;
   localparam int BASE_LO = 11;
   localparam int SUB_LO = 4;
   localparam int LIT_LO = 0;
   // Largest shift count that does not clear the result
   localparam logic [15:0] MAX_SHIFT = 16'h000f;
   // Reset values
   localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage

// >>> core/shift_unit.sv
// Purpose: Combinational logical right shift of a word by 0..15
// Assumes: Count already limited to four bits
// Notes: Pure datapath, no state
`timescale 1ns/1ns
module shift_unit
   import lsr_pkg::*;
(
   // Operand and count
   input wire logic [15:0] operand,
   input wire logic [3:0] count,
   // Result
   output logic [15:0] shifted
);
   // Zero fill from the top
   assign shifted = operand >> count;
endmodule

// >>> core/logical_right_shifter.sv
// Purpose: Execute the logical right shift forms and produce result and flags
// Assumes: Decoder presents an instruction with a one-cycle issue strobe and
//          operands already read from the working registers
// Notes: Result and flags are registered, valid one cycle after issue
//        Byte results keep the upper byte zero; write-back uses dest_byte_q to
//        leave the upper byte of the destination untouched
//        Refused amount sub-forms raise illegal, give no done_q pulse and leave result and flags unchanged
`timescale 1ns/1ns
module logical_right_shifter
   import lsr_pkg::*;
(
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Instruction from the decoder
   input wire logic issue,
   input wire logic [23:0] insn,
   // Operands from the working register file
   input wire logic [15:0] source_operand_reg,
   input wire logic [15:0] base_value_reg,
   input wire logic [15:0] amount_reg,
   // Incoming carry
   input wire logic carry_in,
   // Decoded register fields for the register file
   output logic [3:0] src_sel,
   output logic [3:0] base_sel,
   output logic [3:0] amount_sel,
   output logic [2:0] src_mode,
   output logic [2:0] dst_mode,
   // Result towards the destination
   output logic [15:0] dest_operand_reg,
   output logic [3:0] dest_sel_q,
   output logic dest_byte_q,
   output logic done_q,
   // Condition flags
   output logic flag_n_q,
   output logic flag_z_q,
   output logic flag_c_q,
   // Decode status
   output logic illegal
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Opcode match; the two amount forms share their top nine bits
   wire logic [8:0] opc = insn[OPC_HI:OPC_LO];
   wire logic is_one = (opc == OPC_ONE);
   wire logic is_amt = (opc == OPC_AMT);
   // Sub-form code and literal count of the amount forms
   wire logic [2:0] sub_code = insn[SUB_LO +: 3];
   wire logic [3:0] lit_amt = insn[LIT_LO +: 4];
   wire logic is_lit = is_amt && (sub_code == AMT_LIT);
   wire logic is_reg = is_amt && (sub_code == AMT_REG);
   wire logic byte_op = is_one && insn[BYTE_BIT];
   wire logic any_op = is_one || is_lit || is_reg;

   // Field outputs for operand fetch
   assign src_sel = insn[SREG_LO +: 4];
   assign src_mode = insn[SMODE_LO +: 3];
   assign dst_mode = insn[DMODE_LO +: 3];
   assign base_sel = insn[BASE_LO +: 4];
   assign amount_sel = insn[SREG_LO +: 4];
   // Destination register, registered together with the result
   wire logic [3:0] dst_reg = insn[DREG_LO +: 4];
   // Amount forms with bits 6:4 other than 100 or 000 are not shifts
   assign illegal = issue && is_amt && !is_lit && !is_reg;

   // ----------------------------------------------------------------
   // Flag helpers
   // ----------------------------------------------------------------
   // Top bit of the active width: bit 7 in byte mode, bit 15 otherwise
   function automatic logic neg_of(input logic [15:0] v, input logic b);
      return b ? v[7] : v[15];
   endfunction

   // Zero test of the active width; a byte result ignores its upper byte
   function automatic logic zero_of(input logic [15:0] v, input logic b);
      return b ? (v[7:0] == 8'h00) : (v == 16'h0000);
   endfunction

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------
   // Count: literal, low bits of the amount register, or one
   wire logic [3:0] cnt = is_lit ? lit_amt : (is_reg ? amount_reg[3:0] : 4'h1);
   // Byte form zero-extends its source, so zero reaches bit 7 of the result
   wire logic [15:0] opnd = is_one ? (byte_op ? {8'h00, source_operand_reg[7:0]} : source_operand_reg)
                                   : base_value_reg;
   wire logic [15:0] sh;

   // Kept apart so the shifter can be swapped for a faster barrel on its own
   shift_unit u_shift
   (
      .operand(opnd),
      .count(cnt),
      .shifted(sh)
   );

   // Counts above 15 clear the whole result
   wire logic too_far = is_reg && (amount_reg > MAX_SHIFT);
   wire logic [15:0] res = too_far ? 16'h0000 : sh;
   // Byte mode top bit is bit 7, zero filled since upper byte was cleared
   wire logic neg = neg_of(res, byte_op);
   wire logic zer = zero_of(res, byte_op);
   // Only the single-position form moves a bit into carry; the amount forms
   // pass the current carry back so the flag word keeps it
   wire logic carry = is_one ? opnd[0] : carry_in;

   // ----------------------------------------------------------------
   // Result and flag registers
   // ----------------------------------------------------------------
   // Registered so the write-back stage sees a stable word
   // done_q holds with everything else while clk_en is low, so a frozen
   // pipeline sees the same answer again when it resumes
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dest_operand_reg <= RESULT_RST;
         dest_sel_q <= 4'h0;
         dest_byte_q <= 1'b0;
         done_q <= 1'b0;
         flag_n_q <= 1'b0;
         flag_z_q <= 1'b0;
         flag_c_q <= 1'b0;
      end
      else if (clk_en)
      begin
         done_q <= issue && any_op;
         if (issue && any_op)
         begin
            dest_operand_reg <= res;
            dest_sel_q <= dst_reg;
            dest_byte_q <= byte_op;
            flag_n_q <= neg;
            flag_z_q <= zer;
            flag_c_q <= carry;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Checks look one cycle after issue, where the registered answer stands
   a_one_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && is_one |=> flag_c_q == $past(opnd[0]))
      else $error("single shift carry wrong");
   a_one_top: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && is_one |=> (dest_operand_reg[15] == 1'b0) && (!dest_byte_q || !dest_operand_reg[7]))
      else $error("top bit not zero filled");
   a_amt_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && (is_lit || is_reg) |=> flag_c_q == $past(carry_in))
      else $error("amount shift altered carry");
   a_reg_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && is_reg && amount_reg > 16'h000f |=> dest_operand_reg == 16'h0000 && flag_z_q)
      else $error("large amount not cleared");
   a_lit_value: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && is_lit |=> dest_operand_reg == ($past(base_value_reg) >> $past(insn[3:0])))
      else $error("literal shift value wrong");
   a_reg_value: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && is_reg && amount_reg <= 16'h000f
      |=> dest_operand_reg == ($past(base_value_reg) >> $past(amount_reg[3:0])))
      else $error("register shift value wrong");
   a_decode_one: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && insn[23:15] == 9'h1a2 |=> done_q && dest_byte_q == $past(insn[14]))
      else $error("single form not decoded");
   a_reg_done: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && insn[23:15] == 9'h1bc && insn[6:4] == 3'h0 |=> done_q && !dest_byte_q)
      else $error("register form not decoded");

   // ----------------------------------------------------------------
   // Checks on values, hold and refusal
   // ----------------------------------------------------------------
   // Word single shift: bits 15:1 move down, zero enters at the top
   a_one_value: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && is_one && !byte_op
      |=> dest_operand_reg == {1'b0, $past(source_operand_reg[15:1])})
      else $error("word single shift value wrong");
   // Byte single shift: only the low byte of the source takes part
   a_byte_value: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && byte_op |=> dest_operand_reg == {9'h000, $past(source_operand_reg[7:1])})
      else $error("byte single shift value wrong");
   // Byte carry comes from bit 0 of the source itself
   a_byte_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && byte_op |=> flag_c_q == $past(source_operand_reg[0]))
      else $error("byte shift carry wrong");
   // Amount forms always write a full word
   a_amt_word: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && (is_lit || is_reg) |=> !dest_byte_q)
      else $error("amount form marked as byte");
   // The destination field travels with the result
   a_dest_field: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && issue && any_op |=> dest_sel_q == $past(insn[10:7]))
      else $error("destination field lost");
   // Registered N and Z agree with the registered result of the active width
   a_flag_match: assert property (@(posedge mclk) disable iff (!rst_n)
      done_q |-> (flag_n_q == neg_of(dest_operand_reg, dest_byte_q))
      && (flag_z_q == zero_of(dest_operand_reg, dest_byte_q)))
      else $error("flags disagree with result");
   // done_q pulses only for an accepted shift
   a_done_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && !(issue && any_op) |=> !done_q)
      else $error("done without an accepted shift");
   // A low enable freezes the result, done_q and the three flags
   a_freeze_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !clk_en |=> $stable(dest_operand_reg) && $stable(done_q) && $stable(flag_n_q) && $stable(flag_z_q)
      && $stable(flag_c_q))
      else $error("state moved while frozen");
   // A refused amount sub-form leaves result and carry alone
   a_illegal_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && illegal |=> !done_q && $stable(dest_operand_reg) && $stable(flag_c_q))
      else $error("refused form changed state");

endmodule

// >>> tb/reg_file_model.sv
// Purpose: Working register file seen by the shifter's decoded selects
// Assumes: Register direct mode only, fixed contents for the tests
// Notes: Reads are combinational, as the decoder presents them at issue
`timescale 1ns/1ns
module reg_file_model
(
   // Register selects
   input wire logic [3:0] src_sel,
   input wire logic [3:0] base_sel,
   input wire logic [3:0] amount_sel,
   // Operand values
   output logic [15:0] src_val,
   output logic [15:0] base_val,
   output logic [15:0] amt_val
);
   // Fixed contents; W7 holds a count above the legal range
   logic [15:0] regs [16];
   initial
   begin
      for (int i = 0; i < 16; i++)
         regs[i] = 16'h0000;
      regs[0] = 16'hff03;
      regs[1] = 16'h8000;
      regs[4] = 16'hc800;
      regs[5] = 16'h0800;
      regs[6] = 16'h000c;
      regs[7] = 16'h0010;
      regs[8] = 16'hffff;
   end
   // Combinational read ports
   assign src_val = regs[src_sel];
   assign base_val = regs[base_sel];
   assign amt_val = regs[amount_sel];
endmodule

// >>> tb/tb.sv
// Purpose: Self-checking bench for the logical right shifter
// Assumes: Register direct operands from the register file model
// Notes: Each run issues one instruction and checks result and flags
`timescale 1ns/1ns
module tb;
   import lsr_pkg::*;
   logic mclk, rst_n, clk_en, issue, carry_in, d_byte, done_q, fn, fz, fc, illegal;
   logic [23:0] insn;
   logic [15:0] sv, bv, av, dest;
   logic [3:0] s_sel, b_sel, a_sel, d_sel;
   logic [2:0] s_mode, d_mode;
   int fail_count, n_checks, cycles;
   // ----------------------------------------
   // Design and partner
   // ----------------------------------------
   logical_right_shifter u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .issue(issue), .insn(insn),
      .source_operand_reg(sv), .base_value_reg(bv), .amount_reg(av), .carry_in(carry_in), .src_sel(s_sel),
      .base_sel(b_sel), .amount_sel(a_sel), .src_mode(s_mode), .dst_mode(d_mode), .dest_operand_reg(dest),
      .dest_sel_q(d_sel), .dest_byte_q(d_byte), .done_q(done_q), .flag_n_q(fn), .flag_z_q(fz),
      .flag_c_q(fc), .illegal(illegal));
   reg_file_model u_rf (.src_sel(s_sel), .base_sel(b_sel), .amount_sel(a_sel), .src_val(sv),
      .base_val(bv), .amt_val(av));
   // Clock and hang guard
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [23:0] one_f(input logic b, input logic [3:0] d, input logic [3:0] s);
      return {OPC_ONE, b, 3'h0, d, 3'h0, s};
   endfunction
   function automatic logic [23:0] amt_f(input logic [2:0] k, input logic [3:0] b, input logic [3:0] d,
      input logic [3:0] lo);
      return {OPC_AMT, b, d, k, lo};
   endfunction
   // Issue for one cycle, then look at the answer in the cycle it stands
   task automatic run(input logic [23:0] i, input logic cin, input logic [15:0] exp, input logic [2:0] nzc);
      @(posedge mclk);
      issue <= 1'b1;
      insn <= i;
      carry_in <= cin;
      @(posedge mclk);
      issue <= 1'b0;
      #1;
      chk("done", {15'h0, done_q}, 16'h0001);
      chk("result", dest, exp);
      chk("flags", {13'h0, fn, fz, fc}, {13'h0, nzc});
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      fail_count = 0;
      n_checks = 0;
      cycles = 0;
      {rst_n, issue, carry_in} = 3'h0;
      clk_en = 1'b1;
      insn = 24'h000000;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      run(one_f(1'b0, 4'h3, 4'h1), 1'b1, 16'h4000, 3'b000);
      run(one_f(1'b1, 4'h3, 4'h0), 1'b0, 16'h0001, 3'b001);
      chk("byte", {15'h0, d_byte}, 16'h0001);
      run(amt_f(AMT_LIT, 4'h4, 4'h5, 4'he), 1'b1, 16'h0003, 3'b001);
      chk("dest", {12'h0, d_sel}, 16'h0005);
      run(amt_f(AMT_REG, 4'h5, 4'h4, 4'h6), 1'b0, 16'h0000, 3'b010);
      run(amt_f(AMT_REG, 4'h8, 4'h4, 4'h7), 1'b1, 16'h0000, 3'b011);
      run(amt_f(AMT_REG, 4'h8, 4'h4, 4'h2), 1'b0, 16'hffff, 3'b100);
      @(posedge mclk);
      issue <= 1'b1;
      insn <= amt_f(3'h2, 4'h8, 4'h4, 4'h2);
      #1;
      chk("illegal", {15'h0, illegal}, 16'h0001);
      @(posedge mclk);
      issue <= 1'b0;
      #1;
      chk("refused", {15'h0, done_q}, 16'h0000);
      chk("kept", dest, 16'hffff);
      // Mode and select fields stand while the issue stands
      @(posedge mclk);
      issue <= 1'b1;
      insn <= {OPC_ONE, 1'b0, 3'h5, 4'h9, 3'h3, 4'h1};
      #1;
      chk("src_mode", {13'h0, s_mode}, 16'h0003);
      chk("dst_mode", {13'h0, d_mode}, 16'h0005);
      chk("src_sel", {12'h0, s_sel}, 16'h0001);
      chk("not_illegal", {15'h0, illegal}, 16'h0000);
      @(posedge mclk);
      issue <= 1'b0;
      #1;
      chk("dest_sel", {12'h0, d_sel}, 16'h0009);
      chk("mode_result", dest, 16'h4000);
      // A low enable holds an issued shift until it rises again
      @(posedge mclk);
      clk_en <= 1'b0;
      issue <= 1'b1;
      insn <= amt_f(AMT_LIT, 4'h8, 4'h2, 4'h4);
      @(posedge mclk);
      #1;
      chk("frozen_done", {15'h0, done_q}, 16'h0000);
      chk("frozen_result", dest, 16'h4000);
      @(posedge mclk);
      clk_en <= 1'b1;
      @(posedge mclk);
      issue <= 1'b0;
      #1;
      chk("resumed", dest, 16'h0fff);
      chk("resumed_flags", {13'h0, fn, fz, fc}, 16'h0000);
      // Mid-run reset clears every registered output, then a shift runs again
      @(posedge mclk);
      rst_n <= 1'b0;
      #1;
      chk("rst_result", dest, RESULT_RST);
      chk("rst_state", {7'h0, d_sel, d_byte, done_q, fn, fz, fc}, 16'h0000);
      @(posedge mclk);
      rst_n <= 1'b1;
      run(amt_f(AMT_LIT, 4'h1, 4'h6, 4'hf), 1'b1, 16'h0001, 3'b001);
      end_of_test();
   end
endmodule
